// ---- logic/ita_window.sv ----
// register window through which the host reaches the internal switch tables
//
// Implementation choice: the address-and-strobe port.
`include "ita_defs.svh"
`default_nettype none
module ita_window
   import ita_pkg::*;
#(
   parameter int SLOW_READ_CYCLES = `ITA_SLOW_READ_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   output logic o_cmd_valid,
   output logic o_cmd_read,
   output logic [1:0] o_cmd_table,
   output logic [9:0] o_cmd_index,
   output logic [66:0] o_cmd_wdata,
   input wire logic i_tbl_rvalid,
   input wire logic [66:0] i_tbl_rdata,
   output logic o_busy
);
   // ----------------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------------
   // the wait counter is eight bits wide and must count at least once
   if (SLOW_READ_CYCLES < 1 || SLOW_READ_CYCLES > 255) begin : g_bad_param
      $error("SLOW_READ_CYCLES out of range");
   end

   // slow tables report busy while a read is outstanding
   function automatic logic is_slow(input logic [1:0] tsel);
      is_slow = (tsel == ITA_TBL_DYNAMIC) || (tsel == ITA_TBL_MIB);
   endfunction

   logic [2:0] data_top_r;
   logic [15:0] data_47_32_r;
   logic [15:0] data_63_48_r;
   logic [15:0] data_15_0_r;
   logic [15:0] data_31_16_r;
   ita_ctrl_t ctrl_r;
   ita_state_t state_r;
   logic [7:0] wait_cnt_r;
   logic wr_ctrl;
   ita_ctrl_t ctrl_wr;
   logic [66:0] data_all;

   assign wr_ctrl = i_wr && (i_addr == `ITA_OFS_CMD_CTRL);
   assign ctrl_wr = ita_ctrl_t'(i_wdata);
   assign data_all = {data_top_r, data_63_48_r, data_47_32_r, data_31_16_r, data_15_0_r};

   // ----------------------------------------------------------------------
   // control register and command launch
   // ----------------------------------------------------------------------
   // every control write is stored and issues one command
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ctrl_r <= ita_ctrl_t'(`ITA_RST_CTRL);
      end else if (wr_ctrl) begin
         ctrl_r <= ctrl_wr;
      end
   end

   // command strobe towards the tables, one cycle per control write
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_cmd_valid <= 1'b0;
         o_cmd_read <= 1'b0;
         o_cmd_table <= 2'b00;
         o_cmd_index <= 10'h000;
         o_cmd_wdata <= 67'h0;
      end else begin
         o_cmd_valid <= wr_ctrl;
         if (wr_ctrl) begin
            o_cmd_read <= ctrl_wr.dir_read;
            o_cmd_table <= ctrl_wr.table_sel;
            o_cmd_index <= ctrl_wr.index;
            o_cmd_wdata <= data_all;
         end
      end
   end

   // ----------------------------------------------------------------------
   // read tracking and busy flag
   // ----------------------------------------------------------------------
   // a read waits for table data; a read of any table times out after a bounded wait
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_r <= ITA_ST_IDLE;
         wait_cnt_r <= 8'h00;
         o_busy <= 1'b0;
      end else begin
         case (state_r)
            ITA_ST_IDLE: begin
               if (wr_ctrl && ctrl_wr.dir_read) begin
                  state_r <= ITA_ST_WAIT;
                  wait_cnt_r <= 8'(SLOW_READ_CYCLES);
                  o_busy <= is_slow(ctrl_wr.table_sel);
               end
            end
            ITA_ST_WAIT: begin
               if (i_tbl_rvalid || wait_cnt_r == 8'h00) begin
                  state_r <= ITA_ST_IDLE;
                  o_busy <= 1'b0;
               end else begin
                  wait_cnt_r <= wait_cnt_r - 8'h01;
               end
            end
            default: begin
               state_r <= ITA_ST_IDLE;
               o_busy <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------------
   // host writes load the data words; returned table data overwrites them
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         data_top_r <= 3'h0;
         data_47_32_r <= `ITA_RST_DATA;
         data_63_48_r <= `ITA_RST_DATA;
         data_15_0_r <= `ITA_RST_DATA;
         data_31_16_r <= `ITA_RST_DATA;
      end else if (state_r == ITA_ST_WAIT && i_tbl_rvalid) begin
         data_top_r <= i_tbl_rdata[66:64];
         data_63_48_r <= i_tbl_rdata[63:48];
         data_47_32_r <= i_tbl_rdata[47:32];
         data_31_16_r <= i_tbl_rdata[31:16];
         data_15_0_r <= i_tbl_rdata[15:0];
      end else if (i_wr) begin
         case (i_addr)
            `ITA_OFS_DATA_47_32: data_47_32_r <= i_wdata;
            `ITA_OFS_DATA_63_48: data_63_48_r <= i_wdata;
            `ITA_OFS_DATA_15_0: data_15_0_r <= i_wdata;
            `ITA_OFS_DATA_31_16: data_31_16_r <= i_wdata;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // read data port
   // ----------------------------------------------------------------------
   // read data stands the cycle after the strobe, zero otherwise
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            `ITA_OFS_DATA_TOP: o_rdata <= {8'h00, o_busy, 4'h0, data_top_r};
            `ITA_OFS_DATA_47_32: o_rdata <= data_47_32_r;
            `ITA_OFS_DATA_63_48: o_rdata <= data_63_48_r;
            `ITA_OFS_DATA_15_0: o_rdata <= data_15_0_r;
            `ITA_OFS_DATA_31_16: o_rdata <= data_31_16_r;
            `ITA_OFS_CMD_CTRL: o_rdata <= 16'(ctrl_r);
            default: o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end
endmodule : ita_window
`default_nettype wire

// ---- shared/ita_defs.svh ----
// constants of the indirect table access register window
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef ITA_DEFS_SVH
`define ITA_DEFS_SVH
// register offsets (byte addresses of 16-bit registers)
`define ITA_OFS_DATA_TOP 8'h26
`define ITA_OFS_DATA_47_32 8'h28
`define ITA_OFS_DATA_63_48 8'h2a
`define ITA_OFS_DATA_15_0 8'h2c
`define ITA_OFS_DATA_31_16 8'h2e
`define ITA_OFS_CMD_CTRL 8'h30
// field positions and reset values
`define ITA_BIT_DIR 12
`define ITA_BIT_BUSY 7
`define ITA_RST_DATA 16'h0000
`define ITA_RST_CTRL 16'h0000
// wait count of a read; a slow (dynamic or counter) read stays busy at most one cycle more
`define ITA_SLOW_READ_CYCLES 4
`endif

// ---- shared/ita_pkg.sv ----
// types of the indirect table access register window
`default_nettype none
package ita_pkg;
   typedef enum logic [1:0] {
      ITA_TBL_STATIC = 2'b00,
      ITA_TBL_VLAN = 2'b01,
      ITA_TBL_DYNAMIC = 2'b10,
      ITA_TBL_MIB = 2'b11
   } ita_table_t;
   typedef struct packed {
      logic [2:0] rsvd;
      logic dir_read;
      ita_table_t table_sel;
      logic [9:0] index;
   } ita_ctrl_t;
   typedef struct packed {
      logic valid;
      logic read;
      ita_table_t table_sel;
      logic [9:0] index;
      logic [66:0] data;
   } ita_cmd_t;
   typedef enum logic [1:0] {
      ITA_ST_IDLE = 2'b00,
      ITA_ST_WAIT = 2'b01
   } ita_state_t;
endpackage : ita_pkg
`default_nettype wire

// ---- testbench/ita_window_monitor.sv ----
// checker on the table access window ports
`default_nettype none
module ita_window_monitor (
   input wire logic i_core_clk, i_rst_n, i_wr, i_rd, o_cmd_valid, o_cmd_read, i_tbl_rvalid, o_busy,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata, o_rdata,
   input wire logic [1:0] o_cmd_table,
   input wire logic [9:0] o_cmd_index
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // host write of the control register
   sequence c_wr;
      i_wr && i_addr == 8'h30;
   endsequence
   cmd_pulse_a: assert property (c_wr |=> o_cmd_valid) else $error("no cmd");
   cmd_cause_a: assert property (o_cmd_valid |-> $past(i_wr && i_addr == 8'h30)) else $error("stray cmd");
   dir_sel_a: assert property (c_wr |=> o_cmd_read == $past(i_wdata[12])) else $error("dir");
   table_sel_a: assert property (c_wr |=> o_cmd_table == $past(i_wdata[11:10])) else $error("table");
   entry_idx_a: assert property (c_wr |=> o_cmd_index == $past(i_wdata[9:0])) else $error("index");
   busy_set_a: assert property (c_wr ##0 (i_wdata[12:11] == 2'h3 && !o_busy) |=> o_busy)
      else $error("busy set");
   busy_clr_a: assert property (o_busy && i_tbl_rvalid |=> !o_busy) else $error("busy clr");
   top_reg_a: assert property (i_rd && i_addr == 8'h26 |=> o_rdata[15:3] == {8'h0, $past(o_busy), 4'h0})
      else $error("top reg");
endmodule // ita_window_monitor
bind ita_window ita_window_monitor u_mon (.*);
`default_nettype wire

// ---- testbench/ita_table_model.sv ----
// table engine model beyond the command port
`default_nettype none
module ita_table_model (
   input wire logic i_clk, i_rst_n, i_valid, i_read,
   input wire logic [1:0] i_table,
   input wire logic [9:0] i_index,
   input wire logic [66:0] i_wdata,
   output logic o_rvalid,
   output logic [66:0] o_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [66:0] mem [16];
   logic [3:0] key;
   logic [1:0] cnt;
   // odd tables answer a cycle later; idle data toggles so nothing stale looks valid
   always @(posedge i_clk) begin
      o_rvalid <= cnt == 2'h1;
      o_rdata <= (cnt == 2'h1) ? mem[key] : ~o_rdata;
      if (cnt != 2'h0) cnt <= cnt - 2'h1;
      if (i_valid && i_read) cnt <= {1'h0, i_table[0]} + 2'h1;
      if (i_valid && i_read) key <= {i_table, i_index[1:0]};
      // bits 66:64 stand for the entry's own flags
      if (i_valid && !i_read) mem[{i_table, i_index[1:0]}] <= {~i_index[2:0], i_wdata[63:0]};
      if (!i_rst_n) {cnt, o_rvalid, o_rdata} <= '0;
   end
endmodule // ita_table_model
`default_nettype wire

// ---- testbench/ita_window_bench.sv ----
// self-checking bench of the table access window
`default_nettype none
module ita_window_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_core_clk = 1'h0, i_rst_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0, o_cmd_valid, o_cmd_read, i_tbl_rvalid, o_busy;
   logic [7:0] i_addr = 8'h0;
   logic [15:0] i_wdata = 16'h0, o_rdata, v;
   logic [1:0] o_cmd_table;
   logic [9:0] o_cmd_index;
   logic [66:0] o_cmd_wdata, i_tbl_rdata, e;
   int fail_count = 0, tests_run = 0, n;
   logic [7:0] ofs [6] = '{8'h2c, 8'h2e, 8'h28, 8'h2a, 8'h26, 8'h40};
   ita_window DUT (.*);
   ita_table_model far (.i_clk(i_core_clk), .i_rst_n, .i_valid(o_cmd_valid), .i_read(o_cmd_read),
      .i_table(o_cmd_table), .i_index(o_cmd_index), .i_wdata(o_cmd_wdata), .o_rvalid(i_tbl_rvalid),
      .o_rdata(i_tbl_rdata));
   initial forever #50 i_core_clk = ~i_core_clk;
   task automatic chk(input logic [79:0] g, input logic [79:0] x);
      tests_run++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   // one host cycle: write when w is set, else read into v
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= d;
      {i_wr, i_rd} <= {w, !w};
      @(posedge i_core_clk);
      {i_wr, i_rd} <= 2'h0;
      #10 v = o_rdata;
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // reset values; writes to read-only and unmapped places are ignored
   task automatic t_reset;
      bus(1'h1, ofs[4], 16'hffff);
      bus(1'h1, ofs[5], 16'hffff);
      foreach (ofs[k]) begin
         bus(1'h0, ofs[k], 16'h0);
         chk(v, 16'h0);
      end
      bus(1'h0, 8'h30, 16'h0);
      chk(v, 16'h0);
      $display("reset test done");
   endtask
   // write an entry, clear the data registers, read the entry back
   task automatic t_table(input logic [1:0] t, input logic [9:0] ix);
      e = {~ix[2:0], 64'h0};
      for (int k = 0; k < 4; k++) begin
         e[16*k+:16] = 16'h1111 * (k + 1) ^ {14'h0, t};
         bus(1'h1, ofs[k], e[16*k+:16]);
         bus(1'h0, ofs[k], 16'h0);
         chk(v, e[16*k+:16]);
      end
      bus(1'h1, 8'h30, {3'h0, 1'h0, t, ix});
      chk({o_cmd_valid, o_cmd_read, o_cmd_table, o_cmd_index}, {2'h2, t, ix});
      chk(o_cmd_wdata[63:0], e[63:0]);
      for (int k = 0; k < 4; k++) bus(1'h1, ofs[k], 16'h0);
      bus(1'h1, 8'h30, {3'h0, 1'h1, t, ix});
      chk({o_cmd_valid, o_cmd_read, o_cmd_table, o_cmd_index}, {2'h3, t, ix});
      bus(1'h0, ofs[4], 16'h0);
      chk(v[7], t[1]);
      for (n = 0; n < 20 && (n == 0 || v[7] !== 1'h0); n++) bus(1'h0, ofs[4], 16'h0);
      chk(v[7], 1'h0);
      if (v[7] !== 1'h0) wrap_up();
      for (int k = 0; k < 5; k++) begin
         bus(1'h0, ofs[k], 16'h0);
         chk(v, k < 4 ? e[16*k+:16] : {13'h0, e[66:64]});
      end
      $display("table %0d test done", t);
   endtask
   initial begin
      repeat (10) @(posedge i_core_clk);
      i_rst_n <= 1'h1;
      t_reset();
      t_table(2'h0, 10'h3ff);
      t_table(2'h1, 10'h000);
      t_table(2'h2, 10'h155);
      t_table(2'h3, 10'h2aa);
      wrap_up();
   end
endmodule // ita_window_bench
`default_nettype wire
